// >>> tsr_pkg.sv
// Package for the temperature sensor register and shutdown block.
// Assumes a byte-wide register port driven by an SMBus framing engine.
package tsr_pkg;

  localparam logic [2:0] PTR_TEMP = 3'h0;
  localparam logic [2:0] PTR_CONFIG = 3'h1;
  localparam logic [2:0] PTR_UPPER = 3'h2;
  localparam logic [2:0] PTR_LOWER = 3'h3;
  localparam logic [2:0] PTR_CTRL = 3'h4;
  localparam logic [2:0] PTR_IDENT = 3'h7;
  localparam logic [2:0] PTR_RESET = 3'h0;

  localparam logic [15:0] TEMP_RESET = 16'h7ffc;
  localparam logic [15:0] TEMP_ONESHOT = 16'h8000;
  localparam logic [7:0] CONFIG_RESET = 8'h40;
  localparam logic [15:0] UPPER_RESET = 16'h7fe0;
  localparam logic [15:0] LOWER_RESET = 16'h8000;
  localparam logic [1:0] RES_RESET = 2'h0;

  localparam int CFG_SHUTDOWN_POS = 7;
  localparam int CFG_FIXED_ONE_POS = 6;
  localparam int CFG_DISABLE_POS = 5;
  localparam int CFG_POLARITY_POS = 4;
  localparam int CFG_CLEAR_POS = 3;
  localparam int CFG_ONESHOT_POS = 2;
  localparam int CTL_RES_MSB_POS = 6;
  localparam int CTL_RES_LSB_POS = 5;
  localparam int CTL_MIRROR_POS = 3;
  localparam int CTL_HIGH_POS = 2;
  localparam int CTL_LOW_POS = 1;
  localparam int CTL_VALID_POS = 0;

  // Limit comparison uses only the 11-bit field (bits 15:5)
  localparam int CMP_LSB = 5;

  // Longest conversion time per resolution, in microseconds
  localparam int CLK_MHZ = 25;
  localparam int CONV_US_11 = 14000;
  localparam int CONV_US_12 = 28000;
  localparam int CONV_US_13 = 56000;
  localparam int CONV_US_14 = 112000;
  localparam int CONV_CYC_11 = CONV_US_11 * CLK_MHZ;
  localparam int CONV_CYC_12 = CONV_US_12 * CLK_MHZ;
  localparam int CONV_CYC_13 = CONV_US_13 * CLK_MHZ;
  localparam int CONV_CYC_14 = CONV_US_14 * CLK_MHZ;

  typedef enum logic [1:0] {
    TSR_RES_11,
    TSR_RES_12,
    TSR_RES_13,
    TSR_RES_14
  } tsr_res_e;

  // One register access from the SMBus framing engine
  typedef struct packed {
    logic ptr_wr;
    logic data_wr;
    logic data_hi;
    logic [7:0] wdata;
  } tsr_access_s;

endpackage : tsr_pkg

// >>> tsr_conv_seq.sv
// Conversion sequencer: paces conversions and handles shutdown and one-shot.
// Assumes the analogue converter accepts a start pulse and answers with done.
`timescale 1ns/10ps
module tsr_conv_seq #(
  parameter int CYC_11 = tsr_pkg::CONV_CYC_11,
  parameter int CYC_12 = tsr_pkg::CONV_CYC_12,
  parameter int CYC_13 = tsr_pkg::CONV_CYC_13,
  parameter int CYC_14 = tsr_pkg::CONV_CYC_14
) (
  input wire logic clk_i,          // Core clock
  input wire logic rst_i,          // Async reset, active high
  input wire logic shutdown_i,     // Shutdown bit from configuration
  input wire logic oneshot_i,      // One-shot request pulse
  input wire tsr_pkg::tsr_res_e res_i, // Selected resolution
  input wire logic adc_done_i,     // Converter finished
  output logic adc_start_o,        // Converter start pulse
  output logic update_o,           // Result capture pulse
  output logic oneshot_st_o,       // One-shot state flag
  output logic stopped_o,          // In shutdown, idle
  output logic hold_short_o        // Shutdown dropped before hold time
);

  typedef enum logic [1:0] {
    S_START,
    S_CONVERT,
    S_STOPPED
  } tsr_seq_e;

  tsr_seq_e state_q, state_d;
  logic [22:0] hold_q, hold_d;
  logic [22:0] conv_max;
  logic oneshot_st_q, oneshot_st_d;
  logic short_q, short_d;

  assign conv_max = (res_i == tsr_pkg::TSR_RES_11) ? 23'(CYC_11) :
                    (res_i == tsr_pkg::TSR_RES_12) ? 23'(CYC_12) :
                    (res_i == tsr_pkg::TSR_RES_13) ? 23'(CYC_13) : 23'(CYC_14);
  assign adc_start_o = (state_q == S_START);
  assign update_o = (state_q == S_CONVERT) && adc_done_i;
  assign stopped_o = (state_q == S_STOPPED);
  assign oneshot_st_o = oneshot_st_q;
  assign hold_short_o = short_q;

  always_comb begin
    state_d = state_q;
    oneshot_st_d = oneshot_st_q;
    unique case (state_q)
      S_START: state_d = S_CONVERT;
      // A running conversion always finishes before shutdown takes effect
      S_CONVERT: if (adc_done_i) begin
        state_d = shutdown_i ? S_STOPPED : S_START;
        oneshot_st_d = shutdown_i;
      end
      S_STOPPED: if (!shutdown_i || oneshot_i) begin
        state_d = S_START;
      end
      // Two bits hold three states; a stray code restarts conversions
      default: state_d = S_START;
    endcase
  end

  // Time the shutdown bit has been held, saturating at the limit
  assign hold_d = !shutdown_i ? 23'h0 : (hold_q == conv_max) ? hold_q : hold_q + 23'h1;
  assign short_d = shutdown_i ? 1'b0 : (hold_q != 23'h0 && hold_q < conv_max) ? 1'b1 : short_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= S_START;
      oneshot_st_q <= 1'b0;
      hold_q <= 23'h0;
      short_q <= 1'b0;
    end else begin
      state_q <= state_d;
      oneshot_st_q <= oneshot_st_d;
      hold_q <= hold_d;
      short_q <= short_d;
    end
  end

endmodule : tsr_conv_seq

// >>> tsr_regs.sv
// Register, pointer and over-temperature logic of the temperature sensor.
// Assumes an SMBus framing engine on the same clock presents one-cycle
// access strobes and reads RDATA_O; ACK_O answers pointer bytes.
`timescale 1ns/10ps
module tsr_regs #(
  parameter int CYC_11 = tsr_pkg::CONV_CYC_11, // Long counts shortenable
  parameter int CYC_12 = tsr_pkg::CONV_CYC_12,
  parameter int CYC_13 = tsr_pkg::CONV_CYC_13,
  parameter int CYC_14 = tsr_pkg::CONV_CYC_14,
  parameter logic [15:0] IDENT_VALUE = 16'h0a5a // Arbitrary identification value
) (
  input wire logic CLK_I,                    // 25 MHz clock
  input wire logic RST_I,                    // Async power-up reset
  input wire tsr_pkg::tsr_access_s ACC_I,    // Register access strobes
  input wire logic [13:0] ADC_DATA_I,        // Converted temperature
  input wire logic ADC_DONE_I,               // Conversion finished
  output logic ADC_START_O,                  // Start a conversion
  output logic ACK_O,                        // Pointer byte accepted
  output logic [15:0] RDATA_O,               // Selected register value
  output logic [2:0] POINTER_O,              // Current pointer
  output logic OVERTEMP_O,                   // Over-temperature level
  output logic SHUTDOWN_O,                   // Converter idle in shutdown
  output logic HOLD_SHORT_O                  // Shutdown bit held too briefly
);

  logic [2:0] ptr_q;
  logic shutdown_q, disable_q, polarity_q;
  logic [1:0] res_q;
  logic [15:0] temp_q, temp_d;
  logic [15:0] upper_q, lower_q;
  logic [15:0] rdata_q, rdata_d;
  logic alarm_q, alarm_d, high_q, low_q, valid_q;
  logic [7:0] upper_b, lower_b;

  wire ptr_valid = (ACC_I.wdata[7:3] == 5'h0) && (ACC_I.wdata[2:0] != 3'h5) &&
                   (ACC_I.wdata[2:0] != 3'h6);
  wire ptr_take = ACC_I.ptr_wr && ptr_valid;
  wire cfg_wr = ACC_I.data_wr && !ACC_I.data_hi && (ptr_q == tsr_pkg::PTR_CONFIG);
  wire ctl_wr = ACC_I.data_wr && !ACC_I.data_hi && (ptr_q == tsr_pkg::PTR_CTRL);
  wire up_wr = ACC_I.data_wr && (ptr_q == tsr_pkg::PTR_UPPER);
  wire lo_wr = ACC_I.data_wr && (ptr_q == tsr_pkg::PTR_LOWER);
  wire clear_req = cfg_wr && ACC_I.wdata[tsr_pkg::CFG_CLEAR_POS];
  wire oneshot_req = cfg_wr && ACC_I.wdata[tsr_pkg::CFG_ONESHOT_POS];

  wire update;
  wire seq_stopped;

  tsr_conv_seq #(
    .CYC_11(CYC_11),
    .CYC_12(CYC_12),
    .CYC_13(CYC_13),
    .CYC_14(CYC_14)
  ) u_seq (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .shutdown_i(shutdown_q),
    .oneshot_i(oneshot_req),
    .res_i(tsr_pkg::tsr_res_e'(res_q)),
    .adc_done_i(ADC_DONE_I),
    .adc_start_o(ADC_START_O),
    .update_o(update),
    .oneshot_st_o(),
    .stopped_o(seq_stopped),
    .hold_short_o(HOLD_SHORT_O)
  );

  // Resolution trims the low result bits; bits 1:0 always zero
  logic [13:0] masked;
  assign masked = (res_q == 2'h0) ? {ADC_DATA_I[13:3], 3'h0} :
                  (res_q == 2'h1) ? {ADC_DATA_I[13:2], 2'h0} :
                  (res_q == 2'h2) ? {ADC_DATA_I[13:1], 1'h0} : ADC_DATA_I;
  assign temp_d = update ? {masked, 2'h0} :
                  (oneshot_req && seq_stopped) ? tsr_pkg::TEMP_ONESHOT : temp_q;

  // Compare the fresh result at 11-bit precision against the limits
  wire [15:0] new_temp = {masked, 2'h0};
  wire above = $signed(new_temp[15:tsr_pkg::CMP_LSB]) > $signed(upper_q[15:tsr_pkg::CMP_LSB]);
  wire below = $signed(new_temp[15:tsr_pkg::CMP_LSB]) < $signed(lower_q[15:tsr_pkg::CMP_LSB]);

  // A conversion completing above the upper limit with the clear wins, so a live alarm is not lost
  assign alarm_d = (update && above) ? 1'b1 :
                   ((update && below) || clear_req) ? 1'b0 : alarm_q;

  // Pin level follows polarity; disabled output rests at its inactive level
  wire alarm_on = alarm_q && !disable_q;
  wire pin_level = polarity_q ? alarm_on : !alarm_on;

  assign upper_b = ACC_I.wdata & 8'he0;
  assign lower_b = ACC_I.wdata & 8'he0;

  wire [7:0] cfg_read = {shutdown_q, 1'b1, disable_q, polarity_q, 4'h0};
  wire [7:0] ctl_read = {1'b0, res_q, 1'b0, pin_level, high_q, low_q, valid_q};

  always_comb begin
    rdata_d = 16'h0;
    unique case (ptr_q)
      tsr_pkg::PTR_TEMP: rdata_d = temp_q;
      tsr_pkg::PTR_CONFIG: rdata_d = {cfg_read, 8'h0};
      tsr_pkg::PTR_UPPER: rdata_d = upper_q;
      tsr_pkg::PTR_LOWER: rdata_d = lower_q;
      tsr_pkg::PTR_CTRL: rdata_d = {ctl_read, 8'h0};
      tsr_pkg::PTR_IDENT: rdata_d = IDENT_VALUE;
      default: rdata_d = 16'h0;
    endcase
  end

  assign ACK_O = ACC_I.ptr_wr && ptr_valid;
  assign POINTER_O = ptr_q;
  assign OVERTEMP_O = pin_level;
  assign SHUTDOWN_O = seq_stopped;
  assign RDATA_O = rdata_q;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ptr_q <= tsr_pkg::PTR_RESET;
      shutdown_q <= tsr_pkg::CONFIG_RESET[tsr_pkg::CFG_SHUTDOWN_POS];
      disable_q <= tsr_pkg::CONFIG_RESET[tsr_pkg::CFG_DISABLE_POS];
      polarity_q <= tsr_pkg::CONFIG_RESET[tsr_pkg::CFG_POLARITY_POS];
      res_q <= tsr_pkg::RES_RESET;
      temp_q <= tsr_pkg::TEMP_RESET;
      rdata_q <= 16'h0;
    end else begin
      if (ptr_take) begin
        ptr_q <= ACC_I.wdata[2:0];
      end
      if (cfg_wr) begin
        shutdown_q <= ACC_I.wdata[tsr_pkg::CFG_SHUTDOWN_POS];
        disable_q <= ACC_I.wdata[tsr_pkg::CFG_DISABLE_POS];
        polarity_q <= ACC_I.wdata[tsr_pkg::CFG_POLARITY_POS];
      end
      if (ctl_wr) begin
        res_q <= ACC_I.wdata[tsr_pkg::CTL_RES_MSB_POS:tsr_pkg::CTL_RES_LSB_POS];
      end
      temp_q <= temp_d;
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      upper_q <= tsr_pkg::UPPER_RESET;
      lower_q <= tsr_pkg::LOWER_RESET;
      alarm_q <= 1'b0;
      high_q <= 1'b0;
      low_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      if (up_wr && ACC_I.data_hi) begin
        upper_q[15:8] <= ACC_I.wdata;
      end
      if (up_wr && !ACC_I.data_hi) begin
        upper_q[7:0] <= upper_b;
      end
      if (lo_wr && ACC_I.data_hi) begin
        lower_q[15:8] <= ACC_I.wdata;
      end
      if (lo_wr && !ACC_I.data_hi) begin
        lower_q[7:0] <= lower_b;
      end
      alarm_q <= alarm_d;
      if (update) begin
        high_q <= above;
        low_q <= below;
        valid_q <= 1'b1;
      end
    end
  end

endmodule : tsr_regs

// >>> tsr_regs_assertions.sv
// Port checker for the temperature sensor register block.
// Assumes one clock domain and an async active-high reset.
`timescale 1ns/10ps
module tsr_regs_chk (
  input wire logic CLK_I, // Clock
  input wire logic RST_I, // Reset
  input wire tsr_pkg::tsr_access_s ACC_I, // Access strobes
  input wire logic ADC_DONE_I, // Converter done
  input wire logic ADC_START_O, // Converter start
  input wire logic ACK_O, // Pointer accepted
  input wire logic [15:0] RDATA_O, // Read data
  input wire logic [2:0] POINTER_O, // Pointer
  input wire logic SHUTDOWN_O // Stopped
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);
  wire bad_ptr = ACC_I.wdata[7:3] != 5'h00 || ACC_I.wdata[2:0] == 3'h5 || ACC_I.wdata[2:0] == 3'h6;
  a_ptr_ack: assert property (ACC_I.ptr_wr && !bad_ptr |-> ACK_O)
    else $error("valid pointer byte not accepted");
  a_ptr_refuse: assert property (ACC_I.ptr_wr && bad_ptr |-> !ACK_O ##1 POINTER_O == $past(POINTER_O))
    else $error("invalid pointer byte taken");
  a_ptr_load: assert property (ACC_I.ptr_wr && ACK_O |=> POINTER_O == $past(ACC_I.wdata[2:0]))
    else $error("pointer not loaded");
  a_ptr_keep: assert property (!ACC_I.ptr_wr |=> $stable(POINTER_O))
    else $error("pointer changed without a write");
  a_temp_low: assert property ($past(POINTER_O) == 3'h0 |-> RDATA_O[1:0] == 2'h0)
    else $error("result low bits not zero");
  a_cfg_strobes: assert property ($past(POINTER_O) == 3'h1 |-> RDATA_O[11:10] == 2'h0)
    else $error("strobe bits read back set");
  a_stop_done: assert property ($rose(SHUTDOWN_O) |-> $past(ADC_DONE_I) || $past(ADC_DONE_I, 2))
    else $error("stopped without finishing conversion");
  a_stop_quiet: assert property (SHUTDOWN_O |-> !ADC_START_O)
    else $error("conversion started while stopped");
endmodule : tsr_regs_chk
bind tsr_regs tsr_regs_chk u_chk (.CLK_I(CLK_I), .RST_I(RST_I), .ACC_I(ACC_I), .ADC_DONE_I(ADC_DONE_I),
  .ADC_START_O(ADC_START_O), .ACK_O(ACK_O), .RDATA_O(RDATA_O), .POINTER_O(POINTER_O), .SHUTDOWN_O(SHUTDOWN_O));

// >>> tsr_adc_model.sv
// Converter stand-in: answers each start pulse with done after a delay.
// Assumes start is a one-cycle pulse on the core clock.
`timescale 1ns/10ps
module tsr_adc_model #(
  parameter int DELAY = 10
) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic start_i, // Start pulse
  input wire logic [13:0] temp_i, // Value to report
  output logic done_o, // Finished
  output logic [13:0] data_o // Result with done
);
  int cnt;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 0;
      done_o <= 1'b0;
    end else begin
      done_o <= cnt == 1;
      if (start_i) cnt <= DELAY;
      else if (cnt > 0) cnt <= cnt - 1;
    end
  end
  // Garbage outside done so a late sample cannot pass
  assign data_o = done_o ? temp_i : ~temp_i;
endmodule : tsr_adc_model

// >>> testbench.sv
// Testbench: host register accesses, conversions, alarm and shutdown.
// Assumes the converter model answers every start pulse.
`timescale 1ns/10ps
module testbench;
  logic CLK_I = 0, RST_I = 1, done;
  logic [13:0] temp = 14'h0190, data;
  logic ADC_START_O, ACK_O, OVERTEMP_O, SHUTDOWN_O, HOLD_SHORT_O;
  logic [15:0] RDATA_O;
  logic [2:0] POINTER_O;
  logic [7:0] bad[4] = '{8'h05, 8'h06, 8'h0a, 8'h81};
  logic [7:0] good[6] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h07, 8'h01};
  tsr_pkg::tsr_access_s acc = '0;
  int mismatches = 0, num_checks = 0, cyc = 0;
  always #20 CLK_I = ~CLK_I;
  tsr_regs #(.CYC_11(20), .CYC_12(40), .CYC_13(80), .CYC_14(160)) uut (.CLK_I(CLK_I), .RST_I(RST_I),
    .ACC_I(acc), .ADC_DATA_I(data), .ADC_DONE_I(done), .ADC_START_O(ADC_START_O), .ACK_O(ACK_O),
    .RDATA_O(RDATA_O), .POINTER_O(POINTER_O), .OVERTEMP_O(OVERTEMP_O), .SHUTDOWN_O(SHUTDOWN_O),
    .HOLD_SHORT_O(HOLD_SHORT_O));
  tsr_adc_model adc (.clk_i(CLK_I), .rst_i(RST_I), .start_i(ADC_START_O), .temp_i(temp), .done_o(done),
    .data_o(data));
  task finish_test;
    if (mismatches == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task pw(input logic [7:0] v, input logic a);
    acc.ptr_wr = 1'b1;
    acc.wdata = v;
    #1 chk(16'(ACK_O), 16'(a));
    @(negedge CLK_I);
    acc.ptr_wr = 1'b0;
    // One low edge so a following call never re-raises the strobe at once
    @(negedge CLK_I);
  endtask : pw
  task wr(input logic h, input logic [7:0] v);
    acc.data_wr = 1'b1;
    acc.data_hi = h;
    acc.wdata = v;
    @(negedge CLK_I);
    acc.data_wr = 1'b0;
    @(negedge CLK_I);
  endtask : wr
  task cw(input logic [7:0] v);
    pw(8'h01, 1'b1);
    wr(1'b0, v);
  endtask : cw
  task idle(input int n);
    repeat (n) @(negedge CLK_I);
  endtask : idle
  task rd(input logic [15:0] e);
    idle(2);
    chk(RDATA_O, e);
  endtask : rd
  task wsd(input logic e);
    for (int n = 0; n < 300 && SHUTDOWN_O !== e; n++) @(negedge CLK_I);
    chk(16'(SHUTDOWN_O), 16'(e));
  endtask : wsd
  always @(posedge CLK_I) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      finish_test();
    end
  end
  initial begin
    repeat (12) @(posedge CLK_I);
    @(negedge CLK_I);
    RST_I = 0;
    chk(16'(POINTER_O), 16'h0);
    rd(16'h7ffc);
    pw(8'h04, 1'b1);
    rd(16'h0800);
    idle(60);
    rd(16'h0900);
    pw(8'h00, 1'b1);
    rd({temp, 2'b00});
    pw(8'h01, 1'b1);
    rd(16'h4000);
    foreach (bad[i]) begin
      pw(bad[i], 1'b0);
      chk(16'(POINTER_O), 16'h1);
    end
    foreach (good[i]) begin
      pw(good[i], 1'b1);
      chk(16'(POINTER_O), 16'(good[i][2:0]));
    end
    wr(1'b0, 8'h5c);
    rd(16'h5000);
    chk(16'(OVERTEMP_O), 16'h0);
    wr(1'b0, 8'h40);
    pw(8'h00, 1'b1);
    rd({temp, 2'b00});
    chk(16'(OVERTEMP_O), 16'h1);
    pw(8'h02, 1'b1);
    wr(1'b1, 8'h10);
    wr(1'b0, 8'h00);
    rd(16'h1000);
    temp = 14'h0800;
    idle(60);
    chk(16'(OVERTEMP_O), 16'h0);
    cw(8'h50);
    idle(2);
    chk(16'(OVERTEMP_O), 16'h1);
    cw(8'h70);
    idle(2);
    chk(16'(OVERTEMP_O), 16'h0);
    cw(8'h50);
    temp = 14'h0200;
    idle(60);
    chk(16'(OVERTEMP_O), 16'h1);
    cw(8'h58);
    idle(60);
    chk(16'(OVERTEMP_O), 16'h0);
    temp = 14'h0120;
    cw(8'hc0);
    wsd(1'b1);
    pw(8'h00, 1'b1);
    rd(16'h0480);
    temp = 14'h0060;
    cw(8'hc4);
    pw(8'h00, 1'b1);
    rd(16'h8000);
    wsd(1'b1);
    rd(16'h0180);
    cw(8'h40);
    wsd(1'b0);
    chk(16'(HOLD_SHORT_O), 16'h0);
    cw(8'hc0);
    wr(1'b0, 8'h40);
    idle(2);
    chk(16'(HOLD_SHORT_O), 16'h1);
    pw(8'h04, 1'b1);
    for (int r = 0; r < 4; r++) begin
      wr(1'b0, 8'(r << 5));
      idle(2);
      chk(RDATA_O & 16'h6000, 16'(r << 13));
    end
    // Low result bits set, so the resolution trim is visible
    temp = 14'h0193;
    idle(30);
    pw(8'h00, 1'b1);
    rd(16'h064c);
    wr(1'b1, 8'h12);
    rd(16'h064c);
    pw(8'h04, 1'b1);
    wr(1'b0, 8'h00);
    idle(30);
    pw(8'h00, 1'b1);
    rd(16'h0640);
    cw(8'h50);
    RST_I = 1;
    idle(2);
    RST_I = 0;
    chk(16'(POINTER_O), 16'h0);
    chk(16'(HOLD_SHORT_O), 16'h0);
    chk(16'(OVERTEMP_O), 16'h1);
    rd(16'h7ffc);
    pw(8'h01, 1'b1);
    rd(16'h4000);
    finish_test();
  end
endmodule : testbench
